// [core/tbd_regs.svh]
// Field positions and timing constants of the twelve-bit instruction decoder
`ifndef TBD_REGS_SVH
`define TBD_REGS_SVH

`define TBD_WORD_W        12
`define TBD_DEST_BIT      5
`define TBD_FILE_HI       4
`define TBD_FILE_LO       0
`define TBD_BIT_HI        7
`define TBD_BIT_LO        5
`define TBD_LIT_HI        7
`define TBD_WIDE_LIT_HI   8
`define TBD_PHASES        4
`define TBD_MCLK_NS       25
`define TBD_OSC_NS        25
`define TBD_PHASE_CYCLES  ((`TBD_OSC_NS + `TBD_MCLK_NS - 1) / `TBD_MCLK_NS)
`define TBD_FILE_MAX      7'h7F
`define TBD_NOP_WORD      12'h000

`endif

// [core/tbd_pkg.sv]
// Types shared by the instruction decoder files
package tbd_pkg;
	typedef enum logic [1:0] {
		TBD_CLS_BYTE = 2'h0,
		TBD_CLS_BIT  = 2'h1,
		TBD_CLS_LIT  = 2'h3
	} tbd_class_t;

	typedef enum logic [1:0] {
		TBD_Q1 = 2'h0,
		TBD_Q2 = 2'h1,
		TBD_Q3 = 2'h3,
		TBD_Q4 = 2'h2
	} tbd_phase_t;

	typedef enum logic {
		TBD_RUN   = 1'b0,
		TBD_FLUSH = 1'b1
	} tbd_exec_t;
endpackage

// [core/tbd_field_split.sv]
// Field splitter for one latched 12-bit instruction word
`timescale 1ns/1ps
`include "tbd_regs.svh"
module tbd_field_split (
	// Clock and reset
	input  wire logic               mclk,
	input  wire logic               nrst,
	// Word and load strobe
	input  wire logic               load,
	input  wire logic [11:0]        word,
	// Registered fields
	output logic      [6:0]         register_index,
	output logic      [2:0]         position_select,
	output logic      [8:0]         immediate_constant,
	output logic                    result_target
);
	// Fields are cut once per instruction cycle; unused word bits never reach
	// any decode term, so don't-care bits cannot change the outcome
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			register_index     <= 7'h00;
			position_select    <= 3'h0;
			immediate_constant <= 9'h000;
			result_target      <= 1'b0;
		end else if (load) begin
			register_index     <= {2'h0,
				word[`TBD_FILE_HI:`TBD_FILE_LO]};
			position_select    <= word[`TBD_BIT_HI:`TBD_BIT_LO];
			immediate_constant <= word[`TBD_WIDE_LIT_HI:0];
			result_target      <= word[`TBD_DEST_BIT];
		end
	end
endmodule

// [core/tbd_decoder.sv]
// Twelve-bit instruction decoder with instruction-cycle timing
// Overview of operation
// - Each fetched instruction is one 12-bit word of opcode plus operands.
// - Every word falls in exactly one class: byte, bit, or literal/control.
// - Byte class result goes to the accumulator on 0, the file on 1.
// - Bit class picks one bit of an 8-bit file register and its register.
// - Literal class constant is 8 bits, or 9 bits for the wide branch form; the decoder cuts bits 8 to 0 in every form.
// - The register index addresses the file space 0x00 through 0x1F.
// - Don't-care bits never influence decoding; tools should write zeros.
// - One instruction cycle normally, two on a true test or a PC change.
// - An instruction cycle is exactly four oscillator periods.
// - Byte class destination flag is bit 5, file index is bits 4 to 0.
`timescale 1ns/1ps
`include "tbd_regs.svh"
module tbd_decoder
	import tbd_pkg::*;
(
	// Clock and reset
	input  wire logic               mclk,
	input  wire logic               nrst,
	// Program memory side
	input  wire logic [11:0]        fetch_word,
	output logic                    fetch_take,
	// Datapath feedback
	input  wire logic               test_true,
	// Decoded class
	output tbd_pkg::tbd_class_t     instr_class,
	output logic                    is_wide_branch,
	output logic                    changes_pc,
	output logic                    conditional,
	// Operand fields
	output logic      [6:0]         register_index,
	output logic      [2:0]         position_select,
	output logic      [8:0]         immediate_constant,
	output logic                    result_target,
	output logic                    write_accum,
	output logic                    write_file,
	// Timing
	output tbd_pkg::tbd_phase_t     phase,
	output logic                    cycle_start,
	output logic                    exec_valid,
	output logic                    flush_cycle
);
	import tbd_pkg::*;

	logic [11:0]     word;
	tbd_exec_t       exec_state;
	tbd_phase_t      next_phase;
	tbd_class_t      next_class;
	logic            next_wide;
	logic            next_jump;
	logic            next_cond;
	logic            byte_dest_ok;
	logic            two_cycle;

	// Class from the top opcode bits only; lower bits are never consulted
	function automatic tbd_class_t classify(input logic [11:0] w);
		if (w[11:10] == 2'h0)
			classify = TBD_CLS_BYTE;
		else if (w[11:10] == 2'h1)
			classify = TBD_CLS_BIT;
		else
			classify = TBD_CLS_LIT;
	endfunction

	// Skip-style byte ops: decrement/increment with skip
	function automatic logic is_skip_byte(input logic [11:0] w);
		is_skip_byte = (w[11:6] == 6'h0B) || (w[11:6] == 6'h0F);
	endfunction

	// Four-phase sequencer; one instruction cycle per Q1..Q4 lap
	always_comb begin
		case (phase)
			TBD_Q1:  next_phase = TBD_Q2;
			TBD_Q2:  next_phase = TBD_Q3;
			TBD_Q3:  next_phase = TBD_Q4;
			default: next_phase = TBD_Q1;
		endcase
	end

	// Phase advances every oscillator period (equal to mclk here)
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			phase <= TBD_Q1;
		else
			phase <= next_phase;
	end

	// Word is taken at the end of Q4 so a new cycle starts at Q1
	assign fetch_take  = (phase == TBD_Q4);
	assign cycle_start = (phase == TBD_Q1);

	// Latch the whole 12-bit word; a flushed slot decodes as a no-op
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			word <= `TBD_NOP_WORD;
		else if (fetch_take)
			word <= two_cycle ? `TBD_NOP_WORD : fetch_word;
	end

	// Decode of the incoming word, ready when it is latched
	always_comb begin
		next_class = classify(fetch_word);
		next_wide  = (fetch_word[11:9] == 3'h5);
		next_jump  = (fetch_word[11:10] == 2'h2);
		next_cond  = is_skip_byte(fetch_word) ||
			(fetch_word[11:10] == 2'h1 && fetch_word[9]);
	end

	// Class and timing flags, registered with the word
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			instr_class    <= TBD_CLS_BYTE;
			is_wide_branch <= 1'b0;
			changes_pc     <= 1'b0;
			conditional    <= 1'b0;
		end else if (fetch_take) begin
			instr_class    <= two_cycle ? TBD_CLS_BYTE : next_class;
			is_wide_branch <= !two_cycle && next_wide;
			changes_pc     <= !two_cycle && next_jump;
			conditional    <= !two_cycle && next_cond;
		end
	end

	// Operand fields cut from the incoming word as it is latched
	tbd_field_split u_split (
		.mclk               (mclk),
		.nrst               (nrst),
		.load               (fetch_take),
		.word               (two_cycle ? `TBD_NOP_WORD : fetch_word),
		.register_index     (register_index),
		.position_select    (position_select),
		.immediate_constant (immediate_constant),
		.result_target      (result_target)
	);

	// Destination steering only in byte class; the all-zero word is a no-op
	assign byte_dest_ok = (instr_class == TBD_CLS_BYTE) && (word != 12'h000)
		&& (exec_state == TBD_RUN);
	assign write_accum  = byte_dest_ok && !result_target;
	assign write_file   = byte_dest_ok && result_target;

	// Second cycle is needed on a taken test or any change of flow
	assign two_cycle = (exec_state == TBD_RUN) &&
		(changes_pc || (conditional && test_true));

	// Execution state: a run cycle, or an empty cycle after a two-cycle op
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			exec_state <= TBD_RUN;
		else if (fetch_take)
			exec_state <= two_cycle ? TBD_FLUSH : TBD_RUN;
	end

	assign exec_valid  = (exec_state == TBD_RUN);
	assign flush_cycle = (exec_state == TBD_FLUSH);
endmodule

// [test/tbd_decoder_sva.sv]
// Timing and field checks on the decoder ports
`timescale 1ns/1ps
module tbd_decoder_sva
	import tbd_pkg::*;
(
	// Clock, reset and inputs
	input wire logic                mclk,
	input wire logic                nrst,
	input wire logic [11:0]         fetch_word,
	input wire logic                test_true,
	input wire logic                fetch_take,
	// Decoded outputs
	input wire tbd_pkg::tbd_class_t instr_class,
	input wire logic                changes_pc,
	input wire logic                conditional,
	input wire logic [6:0]          register_index,
	input wire logic [2:0]          position_select,
	input wire logic [8:0]          immediate_constant,
	input wire logic                result_target,
	input wire logic                write_file,
	input wire tbd_pkg::tbd_phase_t phase,
	input wire logic                flush_cycle
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	// A word taken and not dropped
	sequence fresh_s; fetch_take ##1 !flush_cycle; endsequence
	phase_walk_a: assert property (phase == TBD_Q1 |=> phase == TBD_Q2 ##1
		phase == TBD_Q3 ##1 phase == TBD_Q4 ##1 phase == TBD_Q1) else $error("phase order");
	take_once_a: assert property (fetch_take |=> !fetch_take [*3] ##1 fetch_take)
		else $error("take spacing");
	class_map_a: assert property (fresh_s |-> instr_class == ($past(fetch_word[11])
		? TBD_CLS_LIT : $past(fetch_word[10]) ? TBD_CLS_BIT : TBD_CLS_BYTE)) else $error("class");
	dest_flag_a: assert property (fresh_s |-> result_target == $past(fetch_word[5]))
		else $error("destination flag");
	file_index_a: assert property (fresh_s |-> register_index
		== {2'h0, $past(fetch_word[4:0])}) else $error("file index");
	bit_pos_a: assert property (fresh_s |-> position_select == $past(fetch_word[7:5]))
		else $error("bit position");
	literal_a: assert property (fresh_s |-> immediate_constant
		== $past(fetch_word[8:0])) else $error("literal");
	file_write_a: assert property (write_file |-> result_target)
		else $error("file write");
	branch_drop_a: assert property (fetch_take && changes_pc |=> flush_cycle
		&& immediate_constant == 9'h000) else $error("branch flush");
	skip_drop_a: assert property (fetch_take && !flush_cycle |=> flush_cycle
		== ($past(changes_pc) || ($past(conditional) && $past(test_true))))
		else $error("skip");
endmodule
bind tbd_decoder tbd_decoder_sva tbd_decoder_sva_i (.*);

// [test/tbd_fetch_model.sv]
// Program memory that hands one word per instruction cycle
`timescale 1ns/1ps
module tbd_fetch_model (
	// Clock and handshake
	input  wire logic        mclk,
	input  wire logic        nrst,
	input  wire logic        fetch_take,
	// Word to the decoder
	output logic      [11:0] fetch_word
);
	logic [11:0] mem [0:7];
	logic [2:0]  pc;
	// Advance on every take; words are whole, spare bits zero
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) pc <= 3'h0;
		else if (fetch_take) pc <= pc + 3'h1;
	end
	// Outside the take the bus is not held, so show a changed value
	assign fetch_word = fetch_take ? mem[pc] : ~mem[pc];
endmodule

// [test/tbd_decoder_tb.sv]
// Self-checking bench for the decoder
`timescale 1ns/1ps
module tbd_decoder_tb;
	import tbd_pkg::*;
	logic mclk = 0, nrst = 0, test_true = 0, fetch_take, write_accum, write_file;
	logic changes_pc, conditional, result_target, is_wide_branch, flush_cycle;
	logic exec_valid, cycle_start;
	logic [11:0] fetch_word;
	logic [6:0] register_index;
	logic [2:0] position_select;
	logic [8:0] immediate_constant;
	tbd_class_t instr_class;
	tbd_phase_t phase;
	int fails = 0, comparisons = 0;
	always #12.5 mclk = ~mclk;
	tbd_fetch_model tbd_fetch_model_i (.*);
	tbd_decoder tbd_decoder_i (.*);
	task chk(input string n, input logic [11:0] s, e);
		comparisons++;
		if (s !== e) begin fails++; $display("Error %s expected %h seen %h", n, e, s); end
	endtask
	// Set the test input, then land just after the next take
	task nxt(input logic tt);
		test_true = tt;
		@(posedge mclk iff fetch_take); #2;
	endtask
	task s_byte;
		nxt(0); chk("file", write_file, 1); chk("idx", register_index, 5);
		chk("cls", instr_class, TBD_CLS_BYTE); chk("rt", result_target, 1);
		chk("cs", cycle_start, 1); chk("ph", phase, TBD_Q1);
		nxt(0); chk("acc", write_accum, 1); chk("fw", write_file, 0);
		chk("rt", result_target, 0);
	endtask
	task s_bit;
		nxt(0); chk("cls", instr_class, TBD_CLS_BIT); chk("pos", position_select, 7);
		chk("idx", register_index, 12'h1F);
		chk("cond", conditional, 1);
		nxt(1); chk("fl", flush_cycle, 1); chk("ex", exec_valid, 0);
	endtask
	task s_lit;
		nxt(0); chk("wide", is_wide_branch, 1); chk("k", immediate_constant, 12'h012);
		chk("pc", changes_pc, 1); chk("cls", instr_class, TBD_CLS_LIT);
		nxt(0); chk("fl", flush_cycle, 1); chk("ri", register_index, 0);
		nxt(0); chk("k8", immediate_constant[7:0], 12'hFF); chk("fl", flush_cycle, 0);
	endtask
	task report_and_stop;
		$display("fails %0d comparisons %0d", fails, comparisons);
		if (fails == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		tbd_fetch_model_i.mem = '{12'h1E5, 12'h1C5, 12'h7FF, 12'h0AA,
			12'hA12, 12'h123, 12'hCFF, 12'h000};
		repeat (6) @(posedge mclk);
		#2 chk("rfl", flush_cycle, 0); chk("rex", exec_valid, 1);
		chk("rtk", fetch_take, 0);
		nrst = 1;
		s_byte; s_bit; s_lit;
		report_and_stop;
	end
	// Whole run is under 40 cycles
	initial begin #(25 * 400); fails++; report_and_stop; end
endmodule
